//--- accel_pkg.sv
// shared constants and types of the accelerator access handler
package accel_pkg;
    // board select and address spaces
    localparam logic [3:0] BOARD_SEL   = 4'hE;
    localparam logic [4:0] SP_REG      = 5'h0C;
    localparam logic [4:0] SP_CTRL     = 5'h0F;
    localparam logic [6:0] SP_SHAD     = 7'h38;
    localparam logic [5:0] SP_LDPTR    = 6'h1D;
    localparam logic [2:0] SP_MAP      = 3'h2;
    // control register selects (address bits 7..2)
    localparam logic [5:0] CR_IMM      = 6'h00;
    localparam logic [5:0] CR_STAT_CLR = 6'h01;
    localparam logic [5:0] CR_STAT_STB = 6'h02;
    localparam logic [5:0] CR_FLUSH    = 6'h03;
    localparam logic [5:0] CR_MASK     = 6'h04;
    localparam logic [5:0] CR_STATE    = 6'h05;
    // immediate error register bits
    localparam int IE_SIZE  = 0;
    localparam int IE_PROT  = 1;
    localparam int IE_ILL   = 2;
    localparam int IE_UCODE = 3;
    localparam int IE_HUNG  = 4;
    localparam int IE_RETRY = 5;
    localparam int IE_CTRL  = 6;
    localparam int IE_BITS  = 7;
    // state register bits
    localparam int SB_REGEN  = 0;
    localparam int SB_LOADEN = 1;
    localparam int SB_UCODE  = 2;
    // arithmetic status register bits
    localparam int ST_INEXACT = 8;
    localparam int ST_WERR    = 9;
    // reset values and counts
    localparam logic [2:0]  STATE_RST   = 3'h0;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    localparam int          RETRY_LIMIT = 256;
    localparam int          STORE_WORDS = 64;
    // bus encodings
    localparam logic [3:0] BE_WORD     = 4'hF;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RESP} bus_state_type;
endpackage

//--- accel_bus_ack_error_handler.sv
// access decode, two-deep pipe and acknowledge/error logic of the accelerator
// How it works
// - decode address bits two to twelve into access type and fields
// - reads fetch the addressed value and return it
// - pipe writes with room capture address and data, then acknowledge
// - arithmetic errors set error indicator, status updated per instruction
// - arithmetic errors come only from issued instructions
// - inexact raises error only when mask bit set; always recorded
// - board errors nack at once and record cause
// - flag non-word, protection and read-only/write-only violations
// - flag microcode with load enable, hung pipe, 256th retry, bad control
// - transparent accesses answer at once, non-transparent wait for pipe
// - with two instructions in pipe, hold next first access
// - with room, both accesses of two-access instruction pass
// - shadow reads pass unless register has pending update
// - clearing status read waits for empty or hung pipe
// - stable status read waits to settle; never nacked for a hung pipe
// - faulting instruction stays in pipe and hangs it
// - immediate error nacks ignoring arithmetic; transparent acks
// - non-transparent: nack if error pending, else wait then decide
// - immediate error changes only the immediate error register
// - any pipe flush write empties pipe, clears error indicator unless an instruction completes with an error in the same cycle
// - each access carries one 32-bit word
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module accel_bus_ack_error_handler #(
    parameter int RETRY_LIMIT = accel_pkg::RETRY_LIMIT,
    parameter int STORE_WORDS = accel_pkg::STORE_WORDS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // avalon-mm slave
    input  wire logic [31:0] address,
    input  wire logic [3:0]  byteenable,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output var  logic [31:0] readdata,
    output var  logic [1:0]  response,
    output var  logic        waitrequest,
    // privilege of the current access
    input  wire logic        hostSuper,
    // instruction issue to the arithmetic unit
    output var  logic        execValid,
    output var  logic [10:0] execInstr,
    output var  logic [31:0] execMs,
    output var  logic [31:0] execLs,
    // completion and result write-back
    input  wire logic        execDone,
    input  wire logic        execError,
    input  wire logic        execInexact,
    input  wire logic [7:0]  execStatus,
    input  wire logic        execWrEn,
    input  wire logic [5:0]  execWrIdx,
    input  wire logic [31:0] execWrData
);

    accel_pkg::bus_state_type state_q;
    accel_pkg::bus_state_type state_d;
    logic [10:0] pAddr_q [2];
    logic [10:0] pAddr_d [2];
    logic [31:0] pMs_q   [2];
    logic [31:0] pMs_d   [2];
    logic [31:0] pLs_q   [2];
    logic [31:0] pLs_d   [2];
    logic [1:0]  pHalf_q;
    logic [1:0]  pHalf_d;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic [31:0] store_q [STORE_WORDS];
    localparam int IE_W = accel_pkg::IE_BITS;
    logic [IE_W-1:0] immediate_error_reg_q;
    logic [IE_W-1:0] immediate_error_reg_d;
    logic [2:0]  stReg_q;
    logic        mask_q;
    logic        werr_q;
    logic        werr_d;
    logic        inexact_q;
    logic [7:0]  stat_q;
    logic [8:0]  waitCnt_q;
    logic        execValid_d;

    // decode
    logic [10:0] wa;
    logic [5:0]  sel;
    logic        isInstr;
    logic        isReg;
    logic        isShad;
    logic        isLdp;
    logic        isCtrl;
    logic        isMap;
    logic        badAddr;
    logic        selStat;
    logic        stableRd;
    assign wa = address[12:2];
    assign sel = address[7:2];
    assign isInstr = wa[10] | (wa[10:9] == 2'h0);
    assign isReg = address[12:8] == accel_pkg::SP_REG;
    assign isShad = address[12:6] == accel_pkg::SP_SHAD;
    assign isLdp = address[12:7] == accel_pkg::SP_LDPTR;
    assign isCtrl = address[12:8] == accel_pkg::SP_CTRL;
    assign isMap = address[12:10] == accel_pkg::SP_MAP;
    // unused bits must be zero and the top nibble selects the board
    assign badAddr = (address[31:28] != accel_pkg::BOARD_SEL) | (address[27:13] != 15'h0000)
                   | (address[1:0] != 2'h0)
                   | !(isInstr | isReg | isShad | isLdp | isCtrl | isMap);
    assign selStat = isCtrl & ((sel == accel_pkg::CR_STAT_CLR) | (sel == accel_pkg::CR_STAT_STB));
    assign stableRd = read & isCtrl & (sel == accel_pkg::CR_STAT_STB);

    // true when the instruction would overwrite lower register r
    function automatic logic hitsReg(input logic [10:0] ia, input logic [4:0] r);
        // extended instructions may touch several registers, so interlock all
        hitsReg = ia[10] | ((ia[10:9] == 2'h0) && ({1'b0, ia[4:1]} == r));
    endfunction

    logic [4:0] rdReg;
    logic [5:0] rdIdx;
    logic       pending;
    assign rdReg = isShad ? {2'h0, address[5:3]} : address[7:3];
    assign rdIdx = {rdReg, address[2]};
    assign pending = ((cnt_q != 2'h0) & hitsReg(pAddr_q[0], rdReg))
                   | ((cnt_q == 2'h2) & hitsReg(pAddr_q[1], rdReg));

    // immediate errors
    logic [IE_W-1:0] immVec;
    logic            immAny;
    logic            ctrlRo;
    assign ctrlRo = (sel == accel_pkg::CR_IMM) | selStat;
    assign immVec[accel_pkg::IE_SIZE] = byteenable != accel_pkg::BE_WORD;
    assign immVec[accel_pkg::IE_PROT] = badAddr
        | (write & isReg & !stReg_q[accel_pkg::SB_REGEN])
        | (isMap & !stReg_q[accel_pkg::SB_LOADEN])
        | (write & isLdp & !stReg_q[accel_pkg::SB_UCODE])
        | (write & isCtrl & !hostSuper
           & ((sel == accel_pkg::CR_STATE) | (sel == accel_pkg::CR_MASK)));
    assign immVec[accel_pkg::IE_ILL] = (write & isShad) | (read & isInstr)
        | (write & isCtrl & ctrlRo) | (read & isCtrl & (sel == accel_pkg::CR_FLUSH));
    assign immVec[accel_pkg::IE_UCODE] = write & isInstr & stReg_q[accel_pkg::SB_LOADEN];
    assign immVec[accel_pkg::IE_HUNG] = 1'b0;
    assign immVec[accel_pkg::IE_RETRY] = (state_q == accel_pkg::S_WAIT)
        & (waitCnt_q == 9'(RETRY_LIMIT - 1));
    assign immVec[accel_pkg::IE_CTRL] = isCtrl & (sel > accel_pkg::CR_STATE);
    assign immAny = |immVec;

    // transparent or not
    logic req;
    logic instrWr;
    logic secondAcc;
    logic firstFull;
    logic pendHit;
    logic statWait;
    logic needWait;
    logic ntEff;
    logic nackW;
    logic accept;
    logic nack;
    assign req = (read | write) & (state_q != accel_pkg::S_RESP);
    assign instrWr = write & isInstr;
    assign secondAcc = instrWr & (cnt_q != 2'h0) & pHalf_q[cnt_q[1]];
    assign firstFull = instrWr & !secondAcc & (cnt_q == 2'h2);
    assign pendHit = read & (isShad | isReg) & pending;
    assign statWait = read & selStat & (cnt_q != 2'h0) & !werr_q;
    assign needWait = firstFull | pendHit | statWait;
    assign ntEff = needWait | (state_q == accel_pkg::S_WAIT);
    // a stable read settles on a hung pipe and never errors
    assign nackW = werr_q & ntEff & !stableRd;
    assign accept = req & !immAny & !nackW & !needWait;
    assign nack = req & (immAny | nackW);

    // accepted side effects
    logic pushFirst;
    logic pushSecond;
    logic flush;
    logic hostWr;
    logic clrIerr;
    logic doneOk;
    logic errNow;
    assign pushFirst = accept & instrWr & !secondAcc;
    assign pushSecond = accept & secondAcc;
    assign flush = accept & write & isCtrl & (sel == accel_pkg::CR_FLUSH);
    assign hostWr = accept & write & isReg;
    assign clrIerr = accept & read & isCtrl & (sel == accel_pkg::CR_IMM);
    // completions only count for an issued instruction
    assign doneOk = execValid & execDone;
    assign errNow = execError | (execInexact & mask_q);

    // read data selection
    logic [31:0] rdMux;
    logic [31:0] statWord;
    assign statWord = {22'h00_0000, werr_q, inexact_q, stat_q};
    assign rdMux = (isReg | isShad) ? store_q[rdIdx]
                 : !isCtrl ? accel_pkg::WORD_RST
                 : (sel == accel_pkg::CR_IMM) ? {25'h000_0000, immediate_error_reg_q}
                 : selStat ? statWord
                 : (sel == accel_pkg::CR_MASK) ? {31'h0000_0000, mask_q}
                 : (sel == accel_pkg::CR_STATE) ? {29'h0000_0000, stReg_q}
                 : accel_pkg::WORD_RST;

    // pipe next state
    always_comb
    begin
        pAddr_d = pAddr_q;
        pMs_d = pMs_q;
        pLs_d = pLs_q;
        pHalf_d = pHalf_q;
        cnt_d = cnt_q;
        if (doneOk & !errNow)
        begin
            pAddr_d[0] = pAddr_q[1];
            pMs_d[0] = pMs_q[1];
            pLs_d[0] = pLs_q[1];
            pHalf_d = {1'b0, pHalf_q[1]};
            cnt_d = cnt_q - 2'h1;
        end
        if (pushFirst)
        begin
            pAddr_d[cnt_d[0]] = wa;
            pMs_d[cnt_d[0]] = writedata;
            pHalf_d[cnt_d[0]] = wa[10] | ((wa[10:9] == 2'h0) & wa[0]);
            cnt_d = cnt_d + 2'h1;
        end
        if (pushSecond)
        begin
            pLs_d[cnt_d[1]] = writedata;
            pHalf_d[cnt_d[1]] = 1'b0;
        end
        if (flush)
        begin
            cnt_d = 2'h0;
            pHalf_d = 2'h0;
        end
    end

    // an error keeps the head in place, so the pipe hangs on it
    assign werr_d = (doneOk & errNow) | (werr_q & !flush);
    assign execValid_d = (cnt_d != 2'h0) & !pHalf_d[0] & !werr_d;
    // a new cause wins over a read that clears the register
    assign immediate_error_reg_d = (clrIerr ? {IE_W{1'b0}} : immediate_error_reg_q)
                  | (nack ? (immAny ? immVec : IE_W'(1 << accel_pkg::IE_HUNG)) : {IE_W{1'b0}});

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            accel_pkg::S_IDLE,
            accel_pkg::S_WAIT:
                if (nack | accept)
                    state_d = accel_pkg::S_RESP;
                else if (req)
                    state_d = accel_pkg::S_WAIT;
            accel_pkg::S_RESP:
                state_d = accel_pkg::S_IDLE;
            default:
                state_d = accel_pkg::S_IDLE;
        endcase
    end

    // bus answer and control state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= accel_pkg::S_IDLE;
            waitrequest <= 1'b1;
            response <= accel_pkg::RESP_OKAY;
            readdata <= accel_pkg::WORD_RST;
            waitCnt_q <= 9'h000;
            immediate_error_reg_q <= {IE_W{1'b0}};
        end
        else
        begin
            state_q <= state_d;
            waitrequest <= !(nack | accept);
            response <= nack ? accel_pkg::RESP_SLVERR : accel_pkg::RESP_OKAY;
            readdata <= (accept & read) ? rdMux : accel_pkg::WORD_RST;
            waitCnt_q <= (state_d == accel_pkg::S_WAIT) ? waitCnt_q + 9'h001 : 9'h000;
            immediate_error_reg_q <= immediate_error_reg_d;
        end
    end

    // registers that software writes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stReg_q <= accel_pkg::STATE_RST;
            mask_q <= 1'b0;
        end
        else if (accept & write & isCtrl)
        begin
            if (sel == accel_pkg::CR_STATE)
                stReg_q <= writedata[2:0];
            if (sel == accel_pkg::CR_MASK)
                mask_q <= writedata[0];
        end
    end

    // arithmetic status
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            werr_q <= 1'b0;
            inexact_q <= 1'b0;
            stat_q <= 8'h00;
        end
        else
        begin
            werr_q <= werr_d;
            if (doneOk)
            begin
                inexact_q <= execInexact;
                stat_q <= execStatus;
            end
        end
    end

    // instruction pipe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                pAddr_q[i] <= 11'h000;
                pMs_q[i] <= accel_pkg::WORD_RST;
                pLs_q[i] <= accel_pkg::WORD_RST;
            end
            pHalf_q <= 2'h0;
            cnt_q <= 2'h0;
            execValid <= 1'b0;
        end
        else
        begin
            pAddr_q <= pAddr_d;
            pMs_q <= pMs_d;
            pLs_q <= pLs_d;
            pHalf_q <= pHalf_d;
            cnt_q <= cnt_d;
            execValid <= execValid_d;
        end
    end
    assign execInstr = pAddr_q[0];
    assign execMs = pMs_q[0];
    assign execLs = pLs_q[0];
    // register storage; host write lands after a result write to the same word
    always_ff @(posedge clk)
    begin
        if (execWrEn)
            store_q[execWrIdx] <= execWrData;
        if (hostWr)
            store_q[rdIdx] <= writedata;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);
    a_size_nack:
        assert property (req & (byteenable != accel_pkg::BE_WORD) |=> !waitrequest && response == accel_pkg::RESP_SLVERR)
        else $error("short access not refused");
    a_imm_no_state:
        assert property (req & immAny |=> cnt_q == $past(cnt_q) && werr_q == $past(werr_q) || $past(doneOk))
        else $error("immediate error changed pipe state");
    a_full_holds:
        assert property (req & firstFull & !werr_q & !immAny & !doneOk |=> waitrequest && state_q == accel_pkg::S_WAIT)
        else $error("third instruction not held");
    a_flush_empties:
        assert property (flush & !doneOk |=> cnt_q == 2'h0 && !werr_q && !execValid)
        else $error("flush left pipe or error");
    a_error_hangs:
        assert property (doneOk & errNow & !pushFirst & !flush |=> cnt_q == $past(cnt_q) && werr_q && !execValid)
        else $error("faulting instruction left pipe");
    a_pending_nack:
        assert property ((state_q == accel_pkg::S_WAIT) & werr_q & !stableRd & req
                         |=> !waitrequest && response == accel_pkg::RESP_SLVERR)
        else $error("pending error not refused");
    a_word_once:
        assert property (!waitrequest |=> waitrequest)
        else $error("answer held longer than one cycle");
    a_masked_inexact:
        assert property (doneOk & !execError & execInexact & !mask_q & !flush |=> werr_q == $past(werr_q) && inexact_q)
        else $error("masked inexact raised error");
    a_werr_source:
        assert property ($rose(werr_q) |-> $past(doneOk))
        else $error("error without completion");
    a_second_pass:
        assert property (req & secondAcc & !immAny & !werr_q |=> !waitrequest && response == accel_pkg::RESP_OKAY)
        else $error("second access stalled");
    a_stable_ok:
        assert property (req & stableRd & !immAny & werr_q |=> response == accel_pkg::RESP_OKAY)
        else $error("stable status read errored");
    c_full_wait: cover property (req & firstFull ##[1:20] accept);
    c_flush: cover property (flush);
    c_hang_nack: cover property (nackW);
    c_two_access: cover property (pushFirst ##[1:10] pushSecond);
endmodule
`default_nettype wire

//--- accel_exec_model.sv
// behavioural model of the arithmetic unit behind the pipe
`timescale 1ns/10ps
`default_nettype none
module accel_exec_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // bench controls
    input  wire logic [7:0]  latency,
    input  wire logic        errOn,
    input  wire logic        inexOn,
    // pipe head
    input  wire logic        execValid,
    input  wire logic [10:0] execInstr,
    input  wire logic [31:0] execMs,
    // completion and write-back
    output var  logic        execDone,
    output var  logic        execError,
    output var  logic        execInexact,
    output var  logic [7:0]  execStatus,
    output var  logic        execWrEn,
    output var  logic [5:0]  execWrIdx,
    output var  logic [31:0] execWrData
);
    logic [7:0] count_q;
    // side data toggles between pulses so stale values are never trusted
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= 8'h00;
            execDone <= 1'b0;
            execWrEn <= 1'b0;
            {execError, execInexact, execStatus, execWrIdx, execWrData} <= '0;
        end
        else
        begin
            execDone <= 1'b0;
            execWrEn <= 1'b0;
            {execError, execInexact, execStatus, execWrIdx, execWrData} <=
                ~{execError, execInexact, execStatus, execWrIdx, execWrData};
            // the done edge itself pops the head, so it is not counted again
            if (execValid && !execDone)
            begin
                if (count_q == latency)
                begin
                    count_q <= 8'h00;
                    execDone <= 1'b1;
                    execWrEn <= 1'b1;
                    {execError, execInexact, execStatus, execWrIdx, execWrData} <=
                        {errOn, inexOn, execMs[7:0], 1'b0, execInstr[4:1], 1'b0, execMs};
                end
                else
                begin
                    count_q <= count_q + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- accel_bus_ack_error_handler_tb_top.sv
// self-checking bench of the access and error handler
`timescale 1ns/10ps
`default_nettype none
module accel_bus_ack_error_handler_tb_top;
    // retry limit well above normal pipe waits
    localparam int          RETRY = 40;
    localparam logic [31:0] IMM   = 32'hE000_0F00;
    localparam logic [31:0] STCLR = 32'hE000_0F04;
    localparam logic [31:0] STSTB = 32'hE000_0F08;
    localparam logic [31:0] FLUSH = 32'hE000_0F0C;
    localparam logic [31:0] MASK  = 32'hE000_0F10;
    localparam logic [31:0] STATE = 32'hE000_0F14;
    localparam logic [1:0]  OK    = accel_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR   = accel_pkg::RESP_SLVERR;
    logic        clk, resetn, read, write, hostSuper, waitrequest;
    logic [31:0] address, writedata, readdata, execMs, execLs, execWrData, rdat;
    logic [3:0]  byteenable;
    logic [1:0]  response, rsp;
    logic        execValid, execDone, execError, execInexact, execWrEn, errOn, inexOn;
    logic [10:0] execInstr;
    logic [7:0]  execStatus, latency;
    logic [5:0]  execWrIdx;
    int          fail_count, compares, cyc;

    always #5 clk = ~clk;

    accel_bus_ack_error_handler #(.RETRY_LIMIT(RETRY), .STORE_WORDS(accel_pkg::STORE_WORDS)) dut (
        .clk(clk), .resetn(resetn), .address(address), .byteenable(byteenable), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .hostSuper(hostSuper), .execValid(execValid),
        .execInstr(execInstr), .execMs(execMs), .execLs(execLs), .execDone(execDone),
        .execError(execError), .execInexact(execInexact), .execStatus(execStatus),
        .execWrEn(execWrEn), .execWrIdx(execWrIdx), .execWrData(execWrData));
    accel_exec_model unit (
        .clk(clk), .resetn(resetn), .latency(latency), .errOn(errOn), .inexOn(inexOn),
        .execValid(execValid), .execInstr(execInstr), .execMs(execMs), .execDone(execDone),
        .execError(execError), .execInexact(execInexact), .execStatus(execStatus),
        .execWrEn(execWrEn), .execWrIdx(execWrIdx), .execWrData(execWrData));

    task automatic print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic chkr(input logic [1:0] e);
        chk({30'h0, rsp}, {30'h0, e});
    endtask

    // one access; request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                       input logic sup);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        hostSuper <= sup;
        read <= ~w;
        write <= w;
        cyc = 0;
        do
        begin
            @(posedge clk);
            cyc++;
        end
        while (waitrequest !== 1'b0 && cyc < 500);
        rdat = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
        if (cyc >= 500)
            chk(32'(cyc), 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hF, 1'b1);
    endtask

    task automatic rd(input logic [31:0] a);
        acc(1'b0, a, 32'h0000_0000, 4'hF, 1'b1);
    endtask

    function automatic logic [31:0] ins(input logic [3:0] op, input logic [3:0] r, input logic s);
        return 32'hE000_0000 | (32'(op) << 7) | (32'(r) << 3) | (32'(s) << 2);
    endfunction

    task automatic t_pipe;
        wr(ins(4'h7, 4'h3, 1'b0), 32'h1111_2222);
        chk(32'(cyc), 32'h2);
        chk(execMs, 32'h1111_2222);
        chk(32'(execInstr), 32'h0000_00E6);
        wr(ins(4'h7, 4'h5, 1'b0), 32'h3333_4444);
        chk(32'(cyc), 32'h2);
        wr(ins(4'h7, 4'h6, 1'b0), 32'h5555_6666);
        chk({31'h0, cyc > 2}, 32'h1);
        chkr(OK);
        rd(STCLR);
        chkr(OK);
        chk(rdat & 32'h0000_03FF, 32'h0000_0066);
        rd(32'hE000_0C28);
        chk(rdat, 32'h3333_4444);
    endtask

    task automatic t_double_shadow;
        wr(ins(4'h7, 4'h1, 1'b1), 32'hDDDD_0001);
        chk(32'(cyc), 32'h2);
        wr(32'hE000_1000, 32'hDDDD_0002);
        chk(32'(cyc), 32'h2);
        chk(execMs, 32'hDDDD_0001);
        chk(execLs, 32'hDDDD_0002);
        rd(STCLR);
        wr(ins(4'h7, 4'h2, 1'b0), 32'hAAAA_0002);
        rd(32'hE000_0E20);
        chk(32'(cyc), 32'h2);
        rd(32'hE000_0E10);
        chk({31'h0, cyc > 2}, 32'h1);
        chk(rdat, 32'hAAAA_0002);
    endtask

    task automatic t_arith;
        latency <= 8'h03;
        inexOn <= 1'b1;
        wr(MASK, 32'h0000_0000);
        wr(ins(4'h7, 4'h1, 1'b0), 32'h0000_0042);
        rd(STCLR);
        chkr(OK);
        chk(rdat & 32'h0000_0300, 32'h0000_0100);
        for (int m = 0; m < 2; m++)
        begin
            wr(MASK, m == 0 ? 32'h0000_0001 : 32'h0000_0000);
            inexOn <= (m == 0);
            errOn <= (m == 1);
            wr(ins(4'h7, 4'h1, 1'b0), 32'h0000_0042);
            rd(STCLR);
            chkr(ERR);
            rd(STSTB);
            chkr(OK);
            chk(rdat & 32'h0000_03FF, m == 0 ? 32'h0000_0342 : 32'h0000_0242);
            chk(32'(execValid), 32'h0);
            chk(32'(execInstr), 32'h0000_00E2);
            wr(ins(4'h7, 4'h2, 1'b0), 32'h0000_0001);
            chkr(OK);
            rd(IMM);
            chk(rdat, 32'h0000_0001 << accel_pkg::IE_HUNG);
            rd(32'hE000_0E08);
            chkr(ERR);
            rd(IMM);
            chk(rdat, 32'h0000_0001 << accel_pkg::IE_HUNG);
            rd(32'hE000_0F18);
            rd(IMM);
            chk(rdat, 32'h0000_0001 << accel_pkg::IE_CTRL);
            wr(FLUSH, 32'h0000_0000);
            chkr(OK);
            rd(STSTB);
            chk(rdat & 32'h0000_0200, 32'h0000_0000);
            chk(32'(execValid), 32'h0);
        end
        errOn <= 1'b0;
        inexOn <= 1'b0;
        wr(MASK, 32'h0000_0000);
    endtask

    task automatic t_immediate;
        logic [31:0] ea [9] = '{32'hE000_0C00, 32'hE000_0C00, 32'hE000_0C00, MASK, 32'hE000_0800, FLUSH,
                                STCLR, 32'hE000_0F18, 32'hE000_0E80};
        logic [8:0]  ew = 9'b1_0100_1110;
        int          eq [9] = '{accel_pkg::IE_SIZE, accel_pkg::IE_PROT, accel_pkg::IE_PROT, accel_pkg::IE_PROT,
                                accel_pkg::IE_PROT, accel_pkg::IE_ILL, accel_pkg::IE_ILL, accel_pkg::IE_CTRL,
                                accel_pkg::IE_PROT};
        // entry two repeats entry one: the same fault must be refused again
        for (int i = 0; i < 9; i++)
        begin
            acc(ew[i], ea[i], 32'h0000_0001, i == 0 ? 4'h3 : 4'hF, i != 3);
            chkr(ERR);
            rd(IMM);
            chk(rdat, 32'h0000_0001 << eq[i]);
        end
        wr(STATE, 32'h0000_0002);
        wr(ins(4'h7, 4'h1, 1'b0), 32'h0000_0005);
        chkr(ERR);
        chk(32'(execValid), 32'h0);
        rd(IMM);
        chk(rdat, 32'h0000_0001 << accel_pkg::IE_UCODE);
        wr(STATE, 32'h0000_0001);
        wr(32'hE000_0C08, 32'h1234_5678);
        chkr(OK);
        rd(32'hE000_0C08);
        chk(rdat, 32'h1234_5678);
        wr(STATE, 32'h0000_0000);
    endtask

    task automatic t_retry;
        latency <= 8'h64;
        wr(ins(4'h7, 4'h1, 1'b0), 32'h0000_0001);
        wr(ins(4'h7, 4'h2, 1'b0), 32'h0000_0002);
        wr(ins(4'h7, 4'h3, 1'b0), 32'h0000_0003);
        chkr(ERR);
        rd(IMM);
        chk(rdat, 32'h0000_0001 << accel_pkg::IE_RETRY);
    endtask

    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        address = 32'h0000_0000;
        byteenable = 4'hF;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        hostSuper = 1'b1;
        latency = 8'h0C;
        errOn = 1'b0;
        inexOn = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk(32'(waitrequest), 32'h1);
        t_pipe;
        t_double_shadow;
        t_arith;
        t_immediate;
        t_retry;
        print_verdict;
    end

    // whole run needs a few hundred cycles
    initial
    begin
        #200_000;
        fail_count++;
        print_verdict;
    end
endmodule
`default_nettype wire
